// *** rtl/pem_pkg.sv ***
// constants, codes and register map of the process event i/o mapper
package pem_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PWAIT = 8'h08;
  localparam logic [7:0] A_TSP = 8'h0C;
  localparam logic [7:0] A_FMIN = 8'h10;
  localparam logic [7:0] A_FMAX = 8'h14;
  localparam logic [7:0] A_MAN = 8'h18;
  localparam logic [7:0] A_RLY = 8'h1C;
  localparam logic [7:0] A_INP = 8'h20;
  // map windows: addr[7:6] selects, addr[5:2] is the channel
  localparam logic [1:0] W_IMAP = 2'h1;
  localparam logic [1:0] W_RMAP = 2'h2;
  // field positions
  localparam int C_MULTI = 0;
  localparam int C_SETUP = 1;
  localparam int S_PERR = 0;
  localparam int S_FERR = 1;
  localparam int S_BUSY = 2;
  localparam int S_EXP = 3;
  // reset values
  localparam logic [15:0] PWAIT_RST = 16'h03E8;
  localparam logic [23:0] TSP_RST = 24'h000000;
  localparam logic [23:0] FMIN_RST = 24'h000000;
  localparam logic [23:0] FMAX_RST = 24'hFFFFFF;
  // timing: 1 ms wait-counter tick and the 1 s crystal move pulse
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int MOVE_MS = 1000;
  localparam int MS_CYC = TICK_NS / CLK_NS;
  localparam int MOVE_CYC = MOVE_MS * MS_CYC;
  typedef enum logic [3:0] {
    IE_NONE = 4'h0, IE_START = 4'h1, IE_ABORT = 4'h2, IE_LSTART = 4'h3,
    IE_LSTOP = 4'h4, IE_LNEXT = 4'h5, IE_FINAL = 4'h6, IE_PROC = 4'h7,
    IE_SOAK = 4'h8, IE_ZTHK = 4'h9, IE_ZTIME = 4'hA, IE_PRDY = 4'hB,
    IE_XRDY = 4'hC
  } pem_iev_t;
  typedef enum logic [4:0] {
    RE_NONE = 5'h00, RE_SRCSH = 5'h01, RE_SNSSH = 5'h02, RE_SFAIL = 5'h03,
    RE_AGOOD = 5'h04, RE_AFAIL = 5'h05, RE_HOLD = 5'h06, RE_DEP = 5'h07,
    RE_PRECOND = 5'h08, RE_SOAKH = 5'h09, RE_ACTIVE = 5'h0A, RE_MANUAL = 5'h0B,
    RE_MAXP = 5'h0C, RE_STOPPED = 5'h0D, RE_TSP = 5'h0E, RE_THK = 5'h0F,
    RE_FINAL = 5'h10, RE_DUAL = 5'h11, RE_MOVE = 5'h12, RE_POCKET = 5'h13
  } pem_rev_t;
  typedef enum logic [3:0] {
    PH_STOP = 4'h0, PH_HOLD = 4'h1, PH_RAMP1 = 4'h2, PH_SOAK1 = 4'h3,
    PH_RAMP2 = 4'h4, PH_SOAK2 = 4'h5, PH_SHDLY = 4'h6, PH_DEP = 4'h7,
    PH_SOAKHOLD = 4'h8, PH_POST = 4'h9
  } pem_phase_t;
  typedef enum logic [0:0] {PK_IDLE = 1'b0, PK_WAIT = 1'b1} pem_pk_t;
endpackage : pem_pkg

// *** rtl/pem_io_mapper.sv ***
// process event i/o mapper: input events, relay events, pocket sequencing
module pem_io_mapper #(
  parameter int MS_CYC = pem_pkg::MS_CYC,
  parameter int MOVE_CYC = pem_pkg::MOVE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [15:0] in_pin,
  input wire logic exp_pin,
  output logic [15:0] relay_o,
  // process state from the controller core
  input wire logic [3:0] phase,
  input wire logic manual_mode,
  input wire logic max_power,
  input wire logic [3:0] sns_fail,
  input wire logic [3:0] layer_sns,
  input wire logic [3:0] film_out,
  input wire logic [3:0] film_sns,
  input wire logic thk_reached,
  input wire logic final_reached,
  input wire logic layer_started,
  input wire logic pocket_go,
  input wire logic [3:0] pocket_num,
  input wire logic [3:0] move_req,
  input wire logic freq_vld,
  input wire logic [23:0] freq_val,
  // events to the controller core
  output logic ev_start,
  output logic ev_abort,
  output logic ev_lstart,
  output logic ev_lstop,
  output logic ev_lnext,
  output logic ev_final,
  output logic ev_proc,
  output logic [4:0] proc_idx,
  output logic ev_zthk,
  output logic ev_ztime,
  output logic soak_hold,
  output logic xtal_ready,
  output logic dep_go
);
  typedef struct packed {
    logic [15:0] s1, s2, s3;
    logic x1, x2;
    logic [1:0] ctrl;
    logic perr, ferr;
    logic [15:0] pwait;
    logic [23:0] tsp, fmin, fmax;
    logic [15:0] man;
    logic [15:0][8:0] imap;
    logic [15:0][7:0] rmap;
    pem_pkg::pem_pk_t pst;
    logic [15:0] pcnt;
    logic [3:0] pocket;
    logic pk_on;
    logic [17:0] tick;
    logic [23:0] dcnt;
    logic thk, fin;
    logic [3:0][27:0] mv;
    logic [15:0] relay;
    logic [9:0] ev;
    logic [4:0] idx;
    logic go;
    logic [31:0] rd;
    logic err;
  } pem_st_t;

  pem_st_t st_r, st_nxt;

  // only the map windows and the fixed words answer; the rest is an error
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a[7:6] == pem_pkg::W_IMAP ||
      a[7:6] == pem_pkg::W_RMAP || a <= pem_pkg::A_INP);
  endfunction : mapped

  function automatic logic in_rng(input logic [23:0] v, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  logic [15:0] en, rise, lvl;
  logic tick, dep, prdy_map, prdy, wr, rdsel, abort_now, perr_set, ferr_set;
  logic [3:0] ch;
  logic [3:0] iev;
  logic [4:0] rev;
  logic [2:0] sel;
  logic v;

  assign pready = 1'b1;
  assign prdata = st_r.rd;
  assign pslverr = st_r.err;
  assign relay_o = st_r.relay;
  assign {ev_start, ev_abort, ev_lstart, ev_lstop, ev_lnext, ev_final,
          ev_proc, ev_zthk, ev_ztime, soak_hold} = st_r.ev;
  assign proc_idx = st_r.idx;
  assign dep_go = st_r.go;
  assign xtal_ready = |(lvl & st_r.s2);

  always_comb begin
    st_nxt = st_r;
    // upper bank only with the expansion strap present
    en = st_r.x2 ? 16'hFFFF : 16'h00FF;
    rise = st_r.s2 & ~st_r.s3 & en;
    lvl = 16'h0000;
    prdy_map = 1'b0;
    prdy = 1'b0;
    perr_set = 1'b0;
    ferr_set = 1'b0;
    st_nxt.s1 = in_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.x1 = exp_pin;
    st_nxt.x2 = st_r.x1;
    st_nxt.ev = 10'h000;
    st_nxt.go = 1'b0;
    for (int i = 0; i < 16; i++) begin
      iev = st_r.imap[i][3:0];
      if (rise[i]) begin
        case (iev)
          pem_pkg::IE_START: st_nxt.ev[9] = 1'b1;
          pem_pkg::IE_ABORT: st_nxt.ev[8] = 1'b1;
          pem_pkg::IE_LSTART: st_nxt.ev[7] = 1'b1;
          pem_pkg::IE_LSTOP: st_nxt.ev[6] = 1'b1;
          pem_pkg::IE_LNEXT: st_nxt.ev[5] = 1'b1;
          pem_pkg::IE_FINAL: st_nxt.ev[4] = 1'b1;
          pem_pkg::IE_ZTHK: st_nxt.ev[2] = 1'b1;
          pem_pkg::IE_ZTIME: st_nxt.ev[1] = 1'b1;
          pem_pkg::IE_PROC: begin
            // an index outside 1..25 launches nothing
            if (st_r.imap[i][8:4] >= 5'h01 && st_r.imap[i][8:4] <= 5'h19) begin
              st_nxt.ev[3] = 1'b1;
              st_nxt.idx = st_r.imap[i][8:4];
            end
          end
          default: ;
        endcase
      end
      if (en[i] && iev == pem_pkg::IE_SOAK && st_r.s2[i])
        st_nxt.ev[0] = 1'b1;
      if (en[i] && iev == pem_pkg::IE_XRDY)
        lvl[i] = 1'b1;
      if (en[i] && iev == pem_pkg::IE_PRDY) begin
        prdy_map = 1'b1;
        prdy = prdy | st_r.s2[i];
      end
    end
    abort_now = st_nxt.ev[8];

    // millisecond tick for the pocket wait
    tick = (st_r.tick == 18'(MS_CYC - 1));
    st_nxt.tick = tick ? 18'h00000 : st_r.tick + 18'h00001;

    // pocket sequencing; soak hold postpones the deposition start
    case (st_r.pst)
      pem_pkg::PK_IDLE: begin
        if (pocket_go) begin
          st_nxt.pocket = pocket_num;
          st_nxt.pk_on = 1'b1;
          st_nxt.pcnt = 16'h0000;
          st_nxt.pst = pem_pkg::PK_WAIT;
        end
      end
      pem_pkg::PK_WAIT: begin
        if (tick && st_r.pcnt != 16'hFFFF)
          st_nxt.pcnt = st_r.pcnt + 16'h0001;
        if (abort_now) begin
          st_nxt.pst = pem_pkg::PK_IDLE;
        end else if (prdy_map) begin
          if (prdy && !st_r.ev[0]) begin
            st_nxt.go = 1'b1;
            st_nxt.pst = pem_pkg::PK_IDLE;
          end else if (st_r.pcnt >= st_r.pwait) begin
            st_nxt.perr = 1'b1;
            perr_set = 1'b1;
            st_nxt.pst = pem_pkg::PK_IDLE;
          end
        end else if (st_r.pcnt >= st_r.pwait && !st_r.ev[0]) begin
          st_nxt.go = 1'b1;
          st_nxt.pst = pem_pkg::PK_IDLE;
        end
      end
      default: st_nxt.pst = pem_pkg::PK_IDLE;
    endcase
    if (phase == pem_pkg::PH_STOP || abort_now)
      st_nxt.pk_on = 1'b0;

    // deposit-phase timer for the time setpoint, cleared by zero time
    dep = (phase == pem_pkg::PH_DEP);
    if (!dep || st_r.ev[1])
      st_nxt.dcnt = 24'h000000;
    else if (tick && st_r.dcnt != 24'hFFFFFF)
      st_nxt.dcnt = st_r.dcnt + 24'h000001;

    // latched thickness relays; a new reach beats the layer-start clear
    if (layer_started) begin
      st_nxt.thk = 1'b0;
      st_nxt.fin = 1'b0;
    end
    if (thk_reached)
      st_nxt.thk = 1'b1;
    if (final_reached)
      st_nxt.fin = 1'b1;

    for (int h = 0; h < 4; h++) begin
      if (move_req[h])
        // full count: the relay stands exactly MOVE_CYC cycles
        st_nxt.mv[h] = 28'(MOVE_CYC);
      else if (st_r.mv[h] != 28'h0000000)
        st_nxt.mv[h] = st_r.mv[h] - 28'h0000001;
    end

    if (freq_vld && !in_rng(freq_val, st_r.fmin, st_r.fmax)) begin
      st_nxt.ferr = 1'b1;
      ferr_set = 1'b1;
    end

    for (int r = 0; r < 16; r++) begin
      rev = st_r.rmap[r][4:0];
      sel = st_r.rmap[r][7:5];
      case (rev)
        pem_pkg::RE_SRCSH: v = dep && film_out[sel[1:0]];
        pem_pkg::RE_SNSSH: v = (dep || phase == pem_pkg::PH_SHDLY) &&
                              film_sns[sel[1:0]];
        pem_pkg::RE_SFAIL: v = sns_fail[sel[1:0]];
        pem_pkg::RE_AGOOD: v = |layer_sns && !(|(layer_sns & sns_fail));
        pem_pkg::RE_AFAIL: v = |layer_sns && ((layer_sns & sns_fail) == layer_sns);
        pem_pkg::RE_HOLD: v = (phase == pem_pkg::PH_HOLD);
        pem_pkg::RE_DEP: v = dep;
        pem_pkg::RE_PRECOND: v = (phase >= pem_pkg::PH_RAMP1 &&
                                  phase <= pem_pkg::PH_SOAK2);
        pem_pkg::RE_SOAKH: v = (phase == pem_pkg::PH_SOAKHOLD);
        pem_pkg::RE_ACTIVE: v = (phase != pem_pkg::PH_STOP &&
                                 phase != pem_pkg::PH_HOLD);
        pem_pkg::RE_STOPPED: v = (phase == pem_pkg::PH_STOP ||
                                  phase == pem_pkg::PH_HOLD);
        pem_pkg::RE_MANUAL: v = manual_mode && phase != pem_pkg::PH_STOP;
        pem_pkg::RE_MAXP: v = max_power;
        pem_pkg::RE_TSP: v = dep && st_r.dcnt >= st_r.tsp;
        pem_pkg::RE_THK: v = st_r.thk;
        pem_pkg::RE_FINAL: v = st_r.fin;
        pem_pkg::RE_DUAL: v = sns_fail[0];
        pem_pkg::RE_MOVE: v = (st_r.mv[sel[1:0]] != 28'h0000000);
        pem_pkg::RE_POCKET: begin
          if (st_r.ctrl[pem_pkg::C_MULTI])
            v = st_r.pk_on && sel <= 3'h3 && st_r.pocket[sel[1:0]];
          else
            v = st_r.pk_on && (st_r.pocket == {1'b0, sel} + 4'h1);
        end
        default: v = 1'b0;
      endcase
      st_nxt.relay[r] = v && en[r];
    end
    // manual toggling; leaving setup falls straight back to the events
    if (st_r.ctrl[pem_pkg::C_SETUP])
      st_nxt.relay = st_r.man & en;

    // apb: read data and error are prepared in the setup cycle
    ch = paddr[5:2];
    rdsel = psel && !penable;
    wr = psel && penable && pwrite && mapped(paddr);
    if (rdsel) begin
      st_nxt.err = !mapped(paddr);
      st_nxt.rd = 32'h00000000;
      case (paddr)
        pem_pkg::A_CTRL: st_nxt.rd[1:0] = st_r.ctrl;
        pem_pkg::A_STAT: st_nxt.rd[3:0] = {st_r.x2, st_r.pst == pem_pkg::PK_WAIT,
                                           st_r.ferr, st_r.perr};
        pem_pkg::A_PWAIT: st_nxt.rd[15:0] = st_r.pwait;
        pem_pkg::A_TSP: st_nxt.rd[23:0] = st_r.tsp;
        pem_pkg::A_FMIN: st_nxt.rd[23:0] = st_r.fmin;
        pem_pkg::A_FMAX: st_nxt.rd[23:0] = st_r.fmax;
        pem_pkg::A_MAN: st_nxt.rd[15:0] = st_r.man;
        pem_pkg::A_RLY: st_nxt.rd[15:0] = st_r.relay;
        pem_pkg::A_INP: st_nxt.rd[15:0] = st_r.s2 & en;
        default: begin
          if (paddr[7:6] == pem_pkg::W_IMAP)
            st_nxt.rd[8:0] = st_r.imap[ch];
          else if (paddr[7:6] == pem_pkg::W_RMAP)
            st_nxt.rd[7:0] = st_r.rmap[ch];
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        pem_pkg::A_CTRL: st_nxt.ctrl = pwdata[1:0];
        pem_pkg::A_STAT: begin
          // write one to clear; an error raised this cycle survives
          if (pwdata[pem_pkg::S_PERR] && !perr_set)
            st_nxt.perr = 1'b0;
          if (pwdata[pem_pkg::S_FERR] && !ferr_set)
            st_nxt.ferr = 1'b0;
        end
        pem_pkg::A_PWAIT: st_nxt.pwait = pwdata[15:0];
        pem_pkg::A_TSP: st_nxt.tsp = pwdata[23:0];
        pem_pkg::A_FMIN: st_nxt.fmin = pwdata[23:0];
        pem_pkg::A_FMAX: st_nxt.fmax = pwdata[23:0];
        pem_pkg::A_MAN: st_nxt.man = pwdata[15:0];
        default: begin
          if (paddr[7:6] == pem_pkg::W_IMAP)
            st_nxt.imap[ch] = pwdata[8:0];
          else if (paddr[7:6] == pem_pkg::W_RMAP)
            st_nxt.rmap[ch] = pwdata[7:0];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.pwait <= pem_pkg::PWAIT_RST;
      st_r.tsp <= pem_pkg::TSP_RST;
      st_r.fmin <= pem_pkg::FMIN_RST;
      st_r.fmax <= pem_pkg::FMAX_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a steady level gives no rise, so no start, abort or process event may follow
  property p_one_shot;
    rise == 16'h0000 |=> !ev_start && !ev_abort && !ev_proc;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("event without an input rise");

  property p_start;
    st_r.s2[0] && !st_r.s3[0] && st_r.imap[0][3:0] == pem_pkg::IE_START |=> ev_start;
  endproperty
  a_start: assert property (p_start) else $error("start edge gave no event");

  property p_single;
    !st_r.ctrl[pem_pkg::C_SETUP] && !st_r.ctrl[pem_pkg::C_MULTI] && st_r.pk_on &&
    st_r.pocket == 4'h3 && st_r.rmap[2] == {3'h2, pem_pkg::RE_POCKET} &&
    st_r.rmap[1] == {3'h1, pem_pkg::RE_POCKET}
    |=> relay_o[2] && !relay_o[1];
  endproperty
  a_single: assert property (p_single) else $error("single pocket relay wrong");

  property p_multi;
    !st_r.ctrl[pem_pkg::C_SETUP] && st_r.ctrl[pem_pkg::C_MULTI] && st_r.pk_on &&
    st_r.pocket == 4'h3 && st_r.rmap[0] == {3'h0, pem_pkg::RE_POCKET} |=> relay_o[0];
  endproperty
  a_multi: assert property (p_multi) else $error("binary pocket relay wrong");

  property p_wait;
    st_r.pst == pem_pkg::PK_WAIT && !prdy_map && !abort_now && !st_r.ev[0] &&
    st_r.pcnt >= st_r.pwait |=> dep_go ##1 !dep_go;
  endproperty
  a_wait: assert property (p_wait) else $error("deposit not started after wait");

  property p_timeout;
    st_r.pst == pem_pkg::PK_WAIT && prdy_map && !prdy && !abort_now &&
    st_r.pcnt >= st_r.pwait |=> st_r.perr && !dep_go;
  endproperty
  a_timeout: assert property (p_timeout) else $error("pocket timeout not flagged");

  property p_move;
    move_req[0] |=> (st_r.mv[0] == 28'(MOVE_CYC)) ##1
      (st_r.mv[0] == 28'(MOVE_CYC - 1) || $past(move_req[0]));
  endproperty
  a_move: assert property (p_move) else $error("move pulse length wrong");

  property p_setup;
    st_r.ctrl[pem_pkg::C_SETUP] |=> relay_o == ($past(st_r.man) & $past(en));
  endproperty
  a_setup: assert property (p_setup) else $error("manual relays not shown");

  property p_freq;
    freq_vld && (freq_val < st_r.fmin || freq_val > st_r.fmax) |=> st_r.ferr;
  endproperty
  a_freq: assert property (p_freq) else $error("bad frequency not flagged");
endmodule : pem_io_mapper

// *** testbench/pem_vac_model.sv ***
// vacuum-side partner: source pocket indexer and multi-crystal sensor head
module pem_vac_model #(
  parameter int RDY_DLY = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // relays seen by the equipment
  input wire logic [15:0] relay_o,
  input wire logic [15:0] pocket_mask,
  input wire logic [15:0] move_mask,
  // a stuck indexer never reports ready
  input wire logic ready_en,
  // ready lines back to the inputs
  output logic pocket_rdy,
  output logic xtal_rdy
);
  timeunit 1ns;
  timeprecision 100ps;
  int pk_n;
  int mv_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pk_n <= 0;
      mv_n <= RDY_DLY;
      pocket_rdy <= 1'b0;
      xtal_rdy <= 1'b1;
    end else begin
      // indexer takes a few cycles to reach the pocket
      if (ready_en && (relay_o & pocket_mask) != 16'h0000) begin
        pk_n <= pk_n + 1;
      end else begin
        pk_n <= 0;
      end
      pocket_rdy <= ready_en && (relay_o & pocket_mask) != 16'h0000 && pk_n >= RDY_DLY;
      // head is off any crystal while it steps
      if ((relay_o & move_mask) != 16'h0000) begin
        mv_n <= 0;
      end else if (mv_n < RDY_DLY) begin
        mv_n <= mv_n + 1;
      end
      xtal_rdy <= (relay_o & move_mask) == 16'h0000 && mv_n >= RDY_DLY;
    end
  end
endmodule : pem_vac_model

// *** testbench/tb_top.sv ***
// self-checking bench for the process event i/o mapper
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, exp_pin = 1'b0, prdy, xrdy, ready_en = 1'b1;
  logic [15:0] tb_pin = 16'h0000, in_pin, relay_o;
  logic [3:0] phase = 4'h0, sns_fail = 4'h0, layer_sns = 4'h0, film_out = 4'h0;
  logic manual_mode = 1'b0, max_power = 1'b0, thk_reached = 1'b0, layer_started = 1'b0;
  logic pocket_go = 1'b0, freq_vld = 1'b0, final_reached = 1'b0;
  logic [3:0] film_sns = 4'h0;
  logic [3:0] pocket_num = 4'h0, move_req = 4'h0;
  logic [23:0] freq_val = 24'h000000;
  logic [8:0] evv;
  logic [4:0] proc_idx;
  logic soak_hold, xtal_ready, dep_go;
  logic [31:0] q;
  logic e;
  int err_total = 0, n_compared = 0, cyc_n = 0, dcnt = 0, n, k;
  int cnt[0:8];
  logic [3:0] iev[0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA};
  logic [59:0] ex;
  always #2 pclk = ~pclk;
  assign in_pin = tb_pin | {4'h0, xrdy, prdy, 10'h000};
  pem_io_mapper #(.MS_CYC(10), .MOVE_CYC(50)) pem_io_mapper_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pin(in_pin), .exp_pin(exp_pin),
    .relay_o(relay_o), .phase(phase), .manual_mode(manual_mode), .max_power(max_power),
    .sns_fail(sns_fail), .layer_sns(layer_sns), .film_out(film_out), .film_sns(film_sns),
    .thk_reached(thk_reached), .final_reached(final_reached), .layer_started(layer_started),
    .pocket_go(pocket_go), .pocket_num(pocket_num), .move_req(move_req), .freq_vld(freq_vld),
    .freq_val(freq_val), .ev_start(evv[0]), .ev_abort(evv[1]), .ev_lstart(evv[2]),
    .ev_lstop(evv[3]), .ev_lnext(evv[4]), .ev_final(evv[5]), .ev_proc(evv[8]),
    .proc_idx(proc_idx), .ev_zthk(evv[6]), .ev_ztime(evv[7]), .soak_hold(soak_hold),
    .xtal_ready(xtal_ready), .dep_go(dep_go));
  pem_vac_model #(.RDY_DLY(4)) pem_vac_model_i (.pclk(pclk), .presetn(presetn),
    .relay_o(relay_o), .pocket_mask(16'h0007), .move_mask(16'h0008), .ready_en(ready_en),
    .pocket_rdy(prdy), .xtal_rdy(xrdy));
  always @(posedge pclk) begin
    for (int i = 0; i < 9; i++) cnt[i] += (evv[i] === 1'b1);
    dcnt += (dep_go === 1'b1);
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] ex_v, input logic [31:0] got);
    n_compared++;
    if (got !== ex_v) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, ex_v, got);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse_in(input int i);
    @(posedge pclk) tb_pin[i] <= 1'b1;
    cyc(10);
    tb_pin[i] <= 1'b0;
    cyc(4);
  endtask : pulse_in
  task automatic go_pocket(input logic [3:0] p);
    @(posedge pclk) pocket_go <= 1'b1;
    pocket_num <= p;
    @(posedge pclk) pocket_go <= 1'b0;
    n = 0;
    while (dep_go !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask : go_pocket
  initial begin
    cyc(7);
    @(posedge pclk) presetn <= 1'b1;
    apb(0, pem_pkg::A_PWAIT, 0); chk("pwait_rst", 32'h000003E8, q);
    apb(0, pem_pkg::A_FMAX, 0); chk("fmax_rst", 32'h00FFFFFF, q);
    apb(0, 8'h24, 0); chk("unmapped_err", 1, e);
    for (k = 0; k < 8; k++) apb(1, 8'h40 + 8'(4 * k), {28'h0, iev[k]});
    apb(1, 8'h60, 32'h00000197);
    apb(1, 8'h64, 32'h00000008);
    apb(1, 8'h68, 32'h0000000B);
    apb(1, 8'h6C, 32'h0000000C);
    for (k = 0; k < 8; k++) begin
      pulse_in(k);
      chk("event_count", 1, cnt[k]);
    end
    pulse_in(8);
    chk("proc_no_exp", 0, cnt[8]);
    @(posedge pclk) exp_pin <= 1'b1;
    cyc(4);
    pulse_in(8);
    chk("proc_count", 1, cnt[8]);
    chk("proc_idx", 25, proc_idx);
    @(posedge pclk) tb_pin[9] <= 1'b1;
    cyc(5);
    chk("soak_hold", 1, soak_hold);
    tb_pin[9] <= 1'b0;
    // relays 0-2 pocket, 3 move, 4-9 phase, 10 thk, 11 time, 12-15 status
    for (k = 0; k < 3; k++) apb(1, 8'h80 + 8'(4 * k), {24'h0, 3'(k), 5'h13});
    ex = {5'h12, 5'h08, 5'h07, 5'h09, 5'h06, 5'h0A, 5'h0D, 5'h0F, 5'h0E, 5'h0B, 5'h0C, 5'h04};
    for (k = 3; k < 15; k++) apb(1, 8'h80 + 8'(4 * k), {27'h0, ex[59 - 5 * (k - 3) -: 5]});
    apb(1, 8'hBC, 32'h00000001);
    apb(1, pem_pkg::A_PWAIT, 2);
    // a pocket-ready input is mapped, so unmap it for the fixed-wait case
    apb(1, 8'h68, 0);
    @(posedge pclk) phase <= 4'h2;
    go_pocket(4'h3);
    chk("wait_not_early", 1, n >= 10);
    chk("wait_bounded", 1, n <= 25);
    chk("single_pocket", 3'b100, relay_o[2:0]);
    @(posedge pclk) phase <= 4'h0;
    cyc(3);
    apb(1, pem_pkg::A_CTRL, 1);
    apb(1, 8'h68, 32'h0000000B);
    apb(1, pem_pkg::A_PWAIT, 5);
    @(posedge pclk) phase <= 4'h2;
    go_pocket(4'h3);
    chk("ready_fast", 1, n <= 20);
    chk("multi_pocket", 3'b011, relay_o[2:0]);
    @(posedge pclk) phase <= 4'h0;
    ready_en <= 1'b0;
    cyc(3);
    @(posedge pclk) phase <= 4'h2;
    dcnt = 0;
    go_pocket(4'h3);
    apb(0, pem_pkg::A_STAT, 0); chk("pocket_timeout", 1, q[0]);
    chk("no_deposit", 0, dcnt);
    apb(1, pem_pkg::A_STAT, 1);
    apb(0, pem_pkg::A_STAT, 0); chk("timeout_clear", 0, q[0]);
    @(posedge pclk) phase <= 4'h0;
    manual_mode <= 1'b1;
    max_power <= 1'b1;
    layer_sns <= 4'h1;
    film_out <= 4'h1;
    for (k = 0; k < 10; k++) begin
      @(posedge pclk) phase <= 4'(k);
      cyc(4);
      ex[5:0] = {k >= 1 && k != 1 ? 1'b0 : 1'b1, k >= 2, k == 1, k == 8, k == 7, k >= 2 && k <= 5};
      ex[5] = (k <= 1);
      ex[9:6] = {k == 7, 1'b1, 1'b1, k != 0};
      chk("phase_relays", ex[9:0], {relay_o[15:12], relay_o[9:4]});
    end
    apb(1, 8'hBC, 32'h00000002);
    @(posedge pclk) phase <= 4'h6;
    film_sns <= 4'h1;
    cyc(4);
    chk("sensor_shutter", 1, relay_o[15]);
    @(posedge pclk) sns_fail <= 4'h1;
    cyc(4);
    chk("all_good_drop", 0, relay_o[14]);
    @(posedge pclk) thk_reached <= 1'b1;
    @(posedge pclk) thk_reached <= 1'b0;
    cyc(20);
    chk("thk_latched", 1, relay_o[10]);
    @(posedge pclk) layer_started <= 1'b1;
    @(posedge pclk) layer_started <= 1'b0;
    cyc(3);
    chk("thk_release", 0, relay_o[10]);
    apb(1, 8'hA8, 32'h00000010);
    @(posedge pclk) final_reached <= 1'b1;
    @(posedge pclk) final_reached <= 1'b0;
    cyc(3);
    chk("final_latched", 1, relay_o[10]);
    apb(1, pem_pkg::A_TSP, 3);
    @(posedge pclk) phase <= 4'h7;
    pulse_in(7);
    chk("time_early", 0, relay_o[11]);
    cyc(30);
    chk("time_reached", 1, relay_o[11]);
    @(posedge pclk) move_req <= 4'h1;
    @(posedge pclk) move_req <= 4'h0;
    // model drops ready a cycle after the relay, then two sync stages
    cyc(5);
    chk("head_moving", 0, xtal_ready);
    n = 0;
    while (relay_o[3] === 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("move_width", 50, n + 3);
    cyc(10);
    chk("head_ready", 1, xtal_ready);
    apb(1, pem_pkg::A_MAN, 32'h0000A5A5);
    apb(1, pem_pkg::A_CTRL, 2);
    cyc(3);
    chk("manual_relays", 16'hA5A5, relay_o);
    apb(1, pem_pkg::A_CTRL, 0);
    cyc(3);
    chk("restored", 1, relay_o[5]);
    apb(1, pem_pkg::A_FMAX, 32'h00001000);
    @(posedge pclk) freq_vld <= 1'b1;
    freq_val <= 24'h002000;
    @(posedge pclk) freq_vld <= 1'b0;
    cyc(4);
    apb(0, pem_pkg::A_STAT, 0); chk("freq_high", 1, q[1]);
    report_and_stop();
  end
endmodule : tb_top
